// file: shared/mdc_pkg.sv
// Purpose: Shared constants and types for the multichannel DMA controller.
// Assumes: One clock domain, parameter set words are 32 bits wide.
// Notes:   Field positions below describe the packed option word of a set.
package mdc_pkg;
  // Default sizes
  localparam int NCH    = 64;  // Event-synchronised channels
  localparam int NQCH   = 8;   // Quick-trigger channels
  localparam int NSET   = 256; // Parameter sets
  localparam int NQ     = 4;   // Event queues and transfer controllers
  localparam int QDEP   = 16;  // Entries per event queue
  localparam int DW     = 64;  // Read and write data width
  localparam int MAXOUT = 4;   // Reads in flight per transfer controller
  localparam int WPS    = 8;   // Words per parameter set (32 bytes)
  localparam int PRIW   = 3;   // Width of one queue priority field
  localparam int TRGW   = 3;   // Width of one trigger word index
  // Word positions inside a set
  localparam int W_OPT  = 0;   // Options
  localparam int W_SRC  = 1;   // Source address
  localparam int W_CNT  = 2;   // Elements per array [15:0], arrays [31:16]
  localparam int W_DST  = 3;   // Destination address
  localparam int W_BIDX = 4;   // Array index, source [15:0], dest [31:16]
  localparam int W_LNK  = 5;   // Link set [15:0], array count reload [31:16]
  localparam int W_CCNT = 6;   // Frame count [15:0]
  localparam int W_CIDX = 7;   // Frame index, source [15:0], dest [31:16]
  // Option word bits
  localparam int O_AB   = 0;   // 1: two dimensions per event
  localparam int O_SC   = 1;   // Source address held constant
  localparam int O_DC   = 2;   // Destination address held constant
  localparam int O_CHEN = 3;   // Chain to the completion code channel
  localparam int O_IEN  = 4;   // Completion interrupt enable
  localparam int O_QL   = 8;   // Target queue, two bits
  localparam int O_TCCL = 12;  // Completion code, six bits
  localparam logic [15:0] LNK_NULL = 16'hFFFF; // No link programmed
  localparam logic [15:0] ONE16    = 16'h0001;
  localparam logic [31:0] ELEM_B   = 32'h0000_0008; // Bytes per 64-bit element

  // Transfer request handed from a queue to a transfer controller
  typedef struct packed {
    logic [31:0] src;
    logic [31:0] dst;
    logic [15:0] acnt;
    logic [15:0] bcnt;
    logic [15:0] sidx;
    logic [15:0] didx;
    logic        sc;
    logic        dc;
    logic        fin;
    logic        chen;
    logic        ien;
    logic [5:0]  tcc;
  } mdc_tr_t;

  // Transfer controller states
  typedef enum logic [1:0] {
    TC_IDLE = 2'b01,
    TC_RUN  = 2'b10
  } mdc_tcst_t;

  // Sign-extend a 16-bit index
  function automatic logic [31:0] mdc_sx(input logic [15:0] v);
    return {{16{v[15]}}, v};
  endfunction
endpackage

// file: design/mdc_dma_top.sv
// Purpose: Channel controller, event queues and four transfer controllers.
// Assumes: Inputs synchronous to mclk; memory ports answer with grants.
// Notes:   Control and status are plain ports; parameter sets sit in flops.
// Behaviour
// - 64 event channels plus 8 quick channels
// - Single-dimension mode: one array per event
// - Two-dimension mode: whole frame per event
// - Increment or constant addresses, separate indexes
// - Chaining raises event on completion-code channel
// - Exhausted set reloads from its link set
// - Completion and error raise interrupts
// - Software event-set write acts as event
// - Each set is eight 32-bit words
// - 256 sets usable by any quick channel or link; event channel n uses set n
// - Trigger word write submits quick transfer
// - Quick channel set mapping is programmable
// - Four queues, each feeds own controller, prioritised
// - Each queue holds sixteen entries
// - Controllers use 64-bit read and write ports
// - At most four reads outstanding per controller
// - Controller does two dimensions, channel side third
// - Watermarks against threshold, error status kept
// - Channel n fixed to event n
// - Events latched even when disabled
`timescale 1ns/100ps
module mdc_xfer
  import mdc_pkg::*;
#(
  parameter int DWID = DW,
  parameter int OUTS = MAXOUT
) (
  // Clock and reset
  input  logic            mclk,
  input  logic            sys_rst,
  // Request from the queue
  input  logic            tr_load,
  input  mdc_tr_t         tr_in,
  output logic            idle_ff,
  output mdc_tr_t         tr_ff,
  // Read port
  output logic            rd_req_ff,
  output logic [31:0]     rd_addr,
  input  logic            rd_gnt,
  input  logic            rd_vld,
  input  logic [DWID-1:0] rd_data,
  input  logic            rd_err,
  // Write port
  output logic            wr_req_ff,
  output logic [31:0]     wr_addr,
  output logic [DWID-1:0] wr_data_ff,
  input  logic            wr_gnt,
  input  logic            wr_err,
  // Completion and fault pulses
  output logic            done_ff,
  output logic            err_ff
);
  localparam int OW = $clog2(OUTS + 1);
  localparam int PW = $clog2(OUTS);
  if (OUTS < 2 || (OUTS & (OUTS - 1)) != 0) $error("OUTS must be a power of two above 1");

  mdc_tcst_t       st_ff, nxt_st;           // Sequencer state
  logic [31:0]     cur_ff[2], base_ff[2];   // Index 0 read side, 1 write side
  logic [31:0]     nxt_cur[2], nxt_base[2];
  logic [15:0]     ac_ff[2], bc_ff[2];      // Elements and arrays still to go
  logic [15:0]     nxt_ac[2], nxt_bc[2];
  logic [31:0]     idx[2];                  // Array step per side
  logic [1:0]      fire, cnst;
  logic [OW-1:0]   outst_ff, nxt_outst;     // Reads granted, not yet written
  logic [OW-1:0]   bufn_ff;                 // Words parked in the buffer
  logic [PW-1:0]   wp_ff, rp_ff;
  logic [DWID-1:0] buf_ff[OUTS];            // Read data waiting for write
  logic            pop, fin_now;

  assign fire      = {wr_req_ff & wr_gnt, rd_req_ff & rd_gnt};
  assign cnst      = {tr_ff.dc, tr_ff.sc};
  assign idx[0]    = mdc_sx(tr_ff.sidx);
  assign idx[1]    = mdc_sx(tr_ff.didx);
  assign rd_addr   = cur_ff[0];
  assign wr_addr   = cur_ff[1];
  assign pop       = (!wr_req_ff || wr_gnt) && bufn_ff != '0;
  assign fin_now   = st_ff == TC_RUN && bc_ff[1] == '0;
  assign nxt_outst = outst_ff + OW'(fire[0]) - OW'(fire[1]);

  // Address walk for both sides: elements inside an array, then array step
  always_comb begin
    for (int s = 0; s < 2; s++) begin
      nxt_cur[s]  = cur_ff[s];
      nxt_base[s] = base_ff[s];
      nxt_ac[s]   = ac_ff[s];
      nxt_bc[s]   = bc_ff[s];
      if (tr_load) begin
        nxt_cur[s]  = (s == 0) ? tr_in.src : tr_in.dst;
        nxt_base[s] = nxt_cur[s];
        nxt_ac[s]   = tr_in.acnt;
        nxt_bc[s]   = tr_in.bcnt;
      end else if (fire[s] && ac_ff[s] > ONE16) begin
        // Next element; constant mode keeps the address
        nxt_ac[s]  = ac_ff[s] - ONE16;
        nxt_cur[s] = cur_ff[s] + (cnst[s] ? '0 : ELEM_B);
      end else if (fire[s]) begin
        // Second dimension handled here
        nxt_ac[s]   = tr_ff.acnt;
        nxt_bc[s]   = bc_ff[s] - ONE16;
        nxt_base[s] = base_ff[s] + idx[s];
        nxt_cur[s]  = base_ff[s] + idx[s];
      end
    end
  end

  // Done once every write of the request is granted
  always_comb begin
    case (st_ff)
      TC_IDLE: nxt_st = tr_load ? TC_RUN : TC_IDLE;
      TC_RUN:  nxt_st = fin_now ? TC_IDLE : TC_RUN;
      default: nxt_st = TC_IDLE;
    endcase
  end

  // Sequencer and port registers
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      st_ff      <= TC_IDLE;
      tr_ff      <= '0;
      cur_ff     <= '{default: '0};
      base_ff    <= '{default: '0};
      ac_ff      <= '{default: '0};
      bc_ff      <= '{default: '0};
      outst_ff   <= '0;
      bufn_ff    <= '0;
      wp_ff      <= '0;
      rp_ff      <= '0;
      rd_req_ff  <= 1'b0;
      wr_req_ff  <= 1'b0;
      wr_data_ff <= '0;
      done_ff    <= 1'b0;
      err_ff     <= 1'b0;
      idle_ff    <= 1'b1;
    end else begin
      st_ff    <= nxt_st;
      cur_ff   <= nxt_cur;
      base_ff  <= nxt_base;
      ac_ff    <= nxt_ac;
      bc_ff    <= nxt_bc;
      outst_ff <= nxt_outst;
      bufn_ff  <= bufn_ff + OW'(rd_vld) - OW'(pop);
      idle_ff  <= nxt_st == TC_IDLE;
      done_ff  <= fin_now;
      err_ff   <= (rd_vld && rd_err) || (fire[1] && wr_err);
      if (tr_load)
        tr_ff <= tr_in;
      // Reads stop while the in-flight limit is reached
      rd_req_ff <= nxt_st == TC_RUN && nxt_bc[0] != '0 && nxt_outst < OW'(OUTS);
      if (rd_vld)
        wp_ff <= wp_ff + 1'b1;
      if (pop) begin
        rp_ff      <= rp_ff + 1'b1;
        wr_data_ff <= buf_ff[rp_ff];
        wr_req_ff  <= 1'b1;
      end else if (wr_gnt) begin
        wr_req_ff <= 1'b0;
      end
    end
  end

  // Data store needs no reset; the counts guard it
  always_ff @(posedge mclk) begin
    if (rd_vld)
      buf_ff[wp_ff] <= rd_data;
  end

  outst_lim_a: assert property (@(posedge mclk) disable iff (sys_rst)
    outst_ff <= OW'(OUTS)) else $error("too many reads in flight");
  bus_err_a: assert property (@(posedge mclk) disable iff (sys_rst)
    (rd_vld && rd_err) |=> err_ff) else $error("read bus error not flagged");
  tr_end_a: assert property (@(posedge mclk) disable iff (sys_rst)
    done_ff |-> idle_ff && outst_ff == '0 && $past(st_ff == TC_RUN))
    else $error("completion with work pending");
endmodule

module mdc_dma_top
  import mdc_pkg::*;
#(
  parameter int NCHAN  = NCH,
  parameter int NQUICK = NQCH,
  parameter int NSETS  = NSET,
  parameter int NQUE   = NQ,
  parameter int QDEPTH = QDEP,
  parameter int DWID   = DW,
  parameter int OUTS   = MAXOUT
) (
  // Clock and reset
  input  logic                     mclk,
  input  logic                     sys_rst,
  // Sync events and channel status
  input  logic [NCHAN-1:0]         ev_in,
  input  logic [NCHAN-1:0]         esr_set,
  input  logic [NCHAN-1:0]         een,
  output logic [NCHAN-1:0]         ev_latch_ff,
  output logic [NCHAN-1:0]         ev_miss_ff,
  input  logic [NCHAN-1:0]         miss_clr,
  // Parameter memory write port
  input  logic                     ps_we,
  input  logic [$clog2(NSETS)-1:0] ps_set,
  input  logic [TRGW-1:0]          ps_word,
  input  logic [31:0]              ps_wdata,
  // Quick-trigger channels
  input  logic [NQUICK-1:0]        qen,
  input  logic [NQUICK*$clog2(NSETS)-1:0] qmap,
  input  logic [NQUICK*TRGW-1:0]   qtrig,
  output logic [NQUICK-1:0]        qpend_ff,
  // Queue priority and watermarks
  input  logic [NQUE*PRIW-1:0]     qpri,
  input  logic [NQUE*$clog2(QDEPTH+1)-1:0] qthr,
  output logic [NQUE*$clog2(QDEPTH+1)-1:0] qwm_ff,
  output logic [NQUE-1:0]          qthr_hit_ff,
  input  logic                     stat_clr,
  // Interrupts and error status
  output logic [NCHAN-1:0]         ipr_ff,
  input  logic [NCHAN-1:0]         ipr_clr,
  output logic                     done_irq_ff,
  output logic                     null_err_ff,
  output logic                     cc_err_irq_ff,
  output logic [NQUE-1:0]          tc_err_ff,
  input  logic                     err_clr,
  output logic                     tc_err_irq_ff,
  // Transfer controller memory ports, one slice each
  output logic [NQUE-1:0]          rd_req_ff,
  output logic [NQUE*32-1:0]       rd_addr,
  input  logic [NQUE-1:0]          rd_gnt,
  input  logic [NQUE-1:0]          rd_vld,
  input  logic [NQUE*DWID-1:0]     rd_data,
  input  logic [NQUE-1:0]          rd_err,
  output logic [NQUE-1:0]          wr_req_ff,
  output logic [NQUE*32-1:0]       wr_addr,
  output logic [NQUE*DWID-1:0]     wr_data_ff,
  input  logic [NQUE-1:0]          wr_gnt,
  input  logic [NQUE-1:0]          wr_err
);
  localparam int SW  = $clog2(NSETS);
  localparam int CW  = $clog2(QDEPTH + 1);
  localparam int QPW = $clog2(QDEPTH);
  localparam int KW  = $clog2(NQUICK);
  if (NCHAN > 64 || NQUE != 4 || NSETS < NCHAN || NSETS > 65535 || NQUICK < 2 ||
      DWID != 64 || (QDEPTH & (QDEPTH - 1)) != 0 || QDEPTH < 2)
    $error("unsupported controller sizing");

  logic [31:0]      pset_ff [NSETS][WPS];   // Parameter sets
  mdc_tr_t          qmem_ff [NQUE][QDEPTH]; // Queue entries
  logic [CW-1:0]    qn_ff[NQUE], nq[NQUE];
  logic [QPW-1:0]   qwp_ff[NQUE], qrp_ff[NQUE];
  logic [NCHAN-1:0] ev_clr, ev_hit, chain_set, ipr_set, nxt_ipr, nxt_miss;
  logic [NQUICK-1:0] q_clr, q_hit;
  logic [NQUE-1:0]  ld, tc_idle, tc_done, tc_err, nxt_tcerr;
  mdc_tr_t          tc_tr[NQUE], tr_new;
  logic [5:0]       pk_ch;
  logic [KW-1:0]    pk_q;
  logic [SW-1:0]    sel;
  logic [1:0]       tq;
  logic [PRIW-1:0]  bp;
  logic             pk_ev, pk_qk, go, push, nul, full, fin, ab, lnk_ok, found, nxt_null;
  logic [31:0]      opt, srca, cnt, dsta, bidx, lnk, ccw, cidx;
  logic [31:0]      nw_src, nw_dst, nw_cnt, nw_cc;

  // Lowest enabled latched channel first, then lowest quick channel
  always_comb begin
    pk_ev = 1'b0;
    pk_ch = '0;
    pk_qk = 1'b0;
    pk_q  = '0;
    for (int i = NCHAN - 1; i >= 0; i--)
      if (ev_latch_ff[i] && een[i]) begin
        pk_ev = 1'b1;
        pk_ch = 6'(i);
      end
    for (int k = NQUICK - 1; k >= 0; k--)
      if (qpend_ff[k]) begin
        pk_qk = 1'b1;
        pk_q  = KW'(k);
      end
  end

  // Channel n always uses set n; quick channels use their map
  assign sel    = pk_ev ? SW'(pk_ch) : qmap[pk_q*SW +: SW];
  assign opt    = pset_ff[sel][W_OPT];
  assign srca   = pset_ff[sel][W_SRC];
  assign cnt    = pset_ff[sel][W_CNT];
  assign dsta   = pset_ff[sel][W_DST];
  assign bidx   = pset_ff[sel][W_BIDX];
  assign lnk    = pset_ff[sel][W_LNK];
  assign ccw    = pset_ff[sel][W_CCNT];
  assign cidx   = pset_ff[sel][W_CIDX];
  assign ab     = opt[O_AB];
  assign tq     = opt[O_QL +: 2];
  // A set with any zero count is null: the trigger is dropped and flagged
  assign nul    = cnt[15:0] == '0 || cnt[31:16] == '0 || ccw[15:0] == '0;
  assign full   = qn_ff[tq] == CW'(QDEPTH);
  assign go     = (pk_ev || pk_qk) && (nul || !full);
  assign push   = go && !nul;
  assign fin    = ccw[15:0] == ONE16 && (ab || cnt[31:16] == ONE16);
  assign lnk_ok = lnk[15:0] != LNK_NULL && 32'(lnk[15:0]) < NSETS;
  // One array per event, or the whole frame per event
  assign tr_new = '{src: srca, dst: dsta, acnt: cnt[15:0],
                    bcnt: ab ? cnt[31:16] : ONE16,
                    sidx: bidx[15:0], didx: bidx[31:16],
                    sc: opt[O_SC], dc: opt[O_DC], fin: fin, chen: opt[O_CHEN],
                    ien: opt[O_IEN], tcc: opt[O_TCCL +: 6]};

  // Set update after submission; frames are the third dimension
  always_comb begin
    nw_src = srca;
    nw_dst = dsta;
    nw_cnt = cnt;
    nw_cc  = ccw;
    if (fin) begin
      nw_cc = {ccw[31:16], 16'h0000};
    end else if (!ab && cnt[31:16] > ONE16) begin
      nw_src = srca + mdc_sx(bidx[15:0]);
      nw_dst = dsta + mdc_sx(bidx[31:16]);
      nw_cnt = {cnt[31:16] - ONE16, cnt[15:0]};
    end else begin
      nw_src = srca + mdc_sx(cidx[15:0]);
      nw_dst = dsta + mdc_sx(cidx[31:16]);
      nw_cnt = {ab ? cnt[31:16] : lnk[31:16], cnt[15:0]};
      nw_cc  = {ccw[31:16], ccw[15:0] - ONE16};
    end
  end

  // Event sources; set wins over a same-cycle clear
  always_comb begin
    chain_set = '0;
    ipr_set   = '0;
    for (int q = 0; q < NQUE; q++)
      if (tc_done[q] && tc_tr[q].fin) begin
        if (tc_tr[q].chen)
          chain_set[tc_tr[q].tcc] = 1'b1;
        if (tc_tr[q].ien)
          ipr_set[tc_tr[q].tcc] = 1'b1;
      end
    q_hit = '0;
    for (int k = 0; k < NQUICK; k++)
      q_hit[k] = ps_we && qen[k] && ps_set == qmap[k*SW +: SW] &&
                 ps_word == qtrig[k*TRGW +: TRGW];
  end
  assign ev_hit    = ev_in | esr_set | chain_set;
  assign ev_clr    = (go && pk_ev) ? (NCHAN'(1) << pk_ch) : '0;
  assign q_clr     = (go && !pk_ev) ? (NQUICK'(1) << pk_q) : '0;
  assign nxt_ipr   = (ipr_ff & ~ipr_clr) | ipr_set;
  assign nxt_miss  = (ev_miss_ff & ~miss_clr) | (ev_hit & ev_latch_ff & ~ev_clr);
  assign nxt_null  = (null_err_ff && !err_clr) || (go && nul);
  assign nxt_tcerr = (tc_err_ff & ~{NQUE{err_clr}}) | tc_err;

  // Queue to controller: best priority value, ties to lowest index
  always_comb begin
    ld    = '0;
    found = 1'b0;
    bp    = '1;
    for (int i = 0; i < NQUE; i++)
      if (qn_ff[i] != '0 && tc_idle[i] && (!found || qpri[i*PRIW +: PRIW] < bp)) begin
        found = 1'b1;
        bp    = qpri[i*PRIW +: PRIW];
        ld    = NQUE'(1) << i;
      end
    for (int i = 0; i < NQUE; i++)
      nq[i] = qn_ff[i] + CW'(push && 32'(tq) == i) - CW'(ld[i]);
  end

  // Parameter memory; a bus write lands after the engine's update
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      pset_ff <= '{default: '{default: '0}};
    end else begin
      if (push && fin && lnk_ok) begin
        for (int j = 0; j < WPS; j++)
          pset_ff[sel][j] <= pset_ff[lnk[SW-1:0]][j];
      end else if (push) begin
        pset_ff[sel][W_SRC]  <= nw_src;
        pset_ff[sel][W_DST]  <= nw_dst;
        pset_ff[sel][W_CNT]  <= nw_cnt;
        pset_ff[sel][W_CCNT] <= nw_cc;
      end
      if (ps_we)
        pset_ff[ps_set][ps_word] <= ps_wdata;
    end
  end

  // Latches, queue counters, watermarks and interrupt status
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      ev_latch_ff   <= '0;
      ev_miss_ff    <= '0;
      qpend_ff      <= '0;
      ipr_ff        <= '0;
      null_err_ff   <= 1'b0;
      tc_err_ff     <= '0;
      done_irq_ff   <= 1'b0;
      cc_err_irq_ff <= 1'b0;
      tc_err_irq_ff <= 1'b0;
      qwm_ff        <= '0;
      qthr_hit_ff   <= '0;
      qn_ff         <= '{default: '0};
      qwp_ff        <= '{default: '0};
      qrp_ff        <= '{default: '0};
    end else begin
      ev_latch_ff   <= (ev_latch_ff & ~ev_clr) | ev_hit;
      ev_miss_ff    <= nxt_miss;
      qpend_ff      <= (qpend_ff & ~q_clr) | q_hit;
      ipr_ff        <= nxt_ipr;
      null_err_ff   <= nxt_null;
      tc_err_ff     <= nxt_tcerr;
      done_irq_ff   <= |nxt_ipr;
      cc_err_irq_ff <= (|nxt_miss) || nxt_null;
      tc_err_irq_ff <= |nxt_tcerr;
      qn_ff         <= nq;
      for (int i = 0; i < NQUE; i++) begin
        if (push && 32'(tq) == i)
          qwp_ff[i] <= qwp_ff[i] + 1'b1;
        if (ld[i])
          qrp_ff[i] <= qrp_ff[i] + 1'b1;
        if (stat_clr || nq[i] > qwm_ff[i*CW +: CW])
          qwm_ff[i*CW +: CW] <= nq[i];
        qthr_hit_ff[i] <= (qthr_hit_ff[i] && !stat_clr) || nq[i] > qthr[i*CW +: CW];
      end
    end
  end

  // Queue storage needs no reset
  always_ff @(posedge mclk) begin
    if (push)
      qmem_ff[tq][qwp_ff[tq]] <= tr_new;
  end

  // One controller per queue, 64-bit ports
  for (genvar g = 0; g < NQUE; g++) begin : g_tc
    mdc_xfer #(.DWID(DWID), .OUTS(OUTS)) u_xfer (
      .mclk       (mclk),
      .sys_rst    (sys_rst),
      .tr_load    (ld[g]),
      .tr_in      (qmem_ff[g][qrp_ff[g]]),
      .idle_ff    (tc_idle[g]),
      .tr_ff      (tc_tr[g]),
      .rd_req_ff  (rd_req_ff[g]),
      .rd_addr    (rd_addr[g*32 +: 32]),
      .rd_gnt     (rd_gnt[g]),
      .rd_vld     (rd_vld[g]),
      .rd_data    (rd_data[g*DWID +: DWID]),
      .rd_err     (rd_err[g]),
      .wr_req_ff  (wr_req_ff[g]),
      .wr_addr    (wr_addr[g*32 +: 32]),
      .wr_data_ff (wr_data_ff[g*DWID +: DWID]),
      .wr_gnt     (wr_gnt[g]),
      .wr_err     (wr_err[g]),
      .done_ff    (tc_done[g]),
      .err_ff     (tc_err[g])
    );
  end

  ev_latch_a: assert property (@(posedge mclk) disable iff (sys_rst)
    ev_in != '0 |=> (ev_latch_ff & $past(ev_in)) == $past(ev_in))
    else $error("sync event not latched");
  sw_set_a: assert property (@(posedge mclk) disable iff (sys_rst)
    esr_set != '0 |=> (ev_latch_ff & $past(esr_set)) == $past(esr_set))
    else $error("software event not latched");
  qtrig_a: assert property (@(posedge mclk) disable iff (sys_rst)
    q_hit[0] |=> qpend_ff[0]) else $error("quick trigger lost");
  q_full_a: assert property (@(posedge mclk) disable iff (sys_rst)
    push |-> qn_ff[tq] < CW'(QDEPTH)) else $error("push into full queue");
  one_load_a: assert property (@(posedge mclk) disable iff (sys_rst)
    $onehot0(ld) && (ld & ~tc_idle) == '0) else $error("bad queue dispatch");
  pri_order_a: assert property (@(posedge mclk) disable iff (sys_rst)
    ld[1] |-> !(qn_ff[0] != '0 && tc_idle[0] && qpri[0 +: PRIW] <= qpri[PRIW +: PRIW]))
    else $error("queue priority not kept");
  chain_go_a: assert property (@(posedge mclk) disable iff (sys_rst)
    tc_done[0] && tc_tr[0].fin && tc_tr[0].chen |=> ev_latch_ff[$past(tc_tr[0].tcc)])
    else $error("chain event missing");
endmodule

// file: bench/mdc_mem_model.sv
// Purpose: Memory and slave model behind the four controller ports.
// Assumes: 32 doublewords; byte address bits [7:3] pick one.
// Notes:   Grants every other cycle; top nibble F answers with an error.
`timescale 1ns/100ps
module mdc_mem_model
  import mdc_pkg::*;
(
  // Clock and reset
  input  logic            mclk,
  input  logic            sys_rst,
  // Read side
  input  logic [NQ-1:0]    rd_req_ff,
  input  logic [NQ*32-1:0] rd_addr,
  output logic [NQ-1:0]    rd_gnt,
  output logic [NQ-1:0]    rd_vld,
  output logic [NQ*DW-1:0] rd_data,
  output logic [NQ-1:0]    rd_err,
  // Write side
  input  logic [NQ-1:0]    wr_req_ff,
  input  logic [NQ*32-1:0] wr_addr,
  input  logic [NQ*DW-1:0] wr_data_ff,
  output logic [NQ-1:0]    wr_gnt,
  output logic [NQ-1:0]    wr_err
);
  logic [DW-1:0] mem [0:31]; // Shared storage
  // Slow grants keep the engine honest about holding its requests
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      rd_gnt <= '0;
      rd_vld <= '0;
      rd_err <= '0;
      rd_data <= '0;
      wr_gnt <= '0;
      wr_err <= '0;
      for (int i = 0; i < 32; i++) mem[i] <= 64'h1111_1111_1111_1111 * i;
    end else begin
      for (int g = 0; g < NQ; g++) begin
        rd_gnt[g] <= rd_req_ff[g] & ~rd_gnt[g];
        rd_vld[g] <= rd_req_ff[g] & rd_gnt[g];
        rd_err[g] <= rd_req_ff[g] & rd_gnt[g] & (rd_addr[g*32+28 +: 4] == 4'hF);
        // Stale data is inverted so it never looks valid
        rd_data[g*DW +: DW] <= (rd_req_ff[g] & rd_gnt[g]) ?
                               mem[rd_addr[g*32+3 +: 5]] : ~rd_data[g*DW +: DW];
        wr_gnt[g] <= wr_req_ff[g] & ~wr_gnt[g];
        wr_err[g] <= wr_req_ff[g] & ~wr_gnt[g] & (wr_addr[g*32+28 +: 4] == 4'hF);
        if (wr_req_ff[g] & wr_gnt[g]) mem[wr_addr[g*32+3 +: 5]] <= wr_data_ff[g*DW +: DW];
      end
    end
  end
endmodule

// file: bench/mdc_dma_top_tb.sv
// Purpose: Event, quick channel, chaining-free transfer and bus fault tests.
// Assumes: Inputs driven on the falling edge of mclk.
// Notes:   Expected data follows the model's fill pattern.
`timescale 1ns/100ps
module mdc_dma_top_tb;
  import mdc_pkg::*;
  logic mclk, sys_rst, ps_we, stat_clr, err_clr;
  logic [63:0] ev_in, esr_set, een, miss_clr, ipr_clr, qmap, ev_latch_ff, ev_miss_ff, ipr_ff;
  logic [7:0] ps_set, qen, qpend_ff;
  logic [2:0] ps_word;
  logic [31:0] ps_wdata;
  logic [23:0] qtrig;
  logic [11:0] qpri;
  logic [19:0] qthr, qwm_ff;
  logic [3:0] qthr_hit_ff, tc_err_ff, rd_req_ff, rd_gnt, rd_vld, rd_err, wr_req_ff, wr_gnt, wr_err;
  logic done_irq_ff, null_err_ff, cc_err_irq_ff, tc_err_irq_ff;
  logic [127:0] rd_addr, wr_addr;
  logic [255:0] rd_data, wr_data_ff;
  int errors = 0;
  int cmp_count = 0;
  mdc_dma_top u_mdc_dma_top (.*);
  mdc_mem_model u_mdc_mem_model (.*);
  // Free-running clock
  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end
  // One parameter word write, then a quiet cycle
  task automatic ps(input logic [7:0] s, input logic [2:0] w, input logic [31:0] d);
    ps_set = s;
    ps_word = w;
    ps_wdata = d;
    ps_we = 1'b1;
    @(negedge mclk);
    ps_we = 1'b0;
    @(negedge mclk);
  endtask
  task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
    cmp_count++;
    if (g !== e) begin
      errors++;
      $display("unexpected %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic stop_test;
    if (errors == 0 && cmp_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // Watchdog for a hung transfer
  initial begin
    #40000;
    errors++;
    stop_test;
  end
  initial begin
    {ev_in, esr_set, een, miss_clr, ipr_clr, qmap, qen, qtrig, qpri, qthr} = '0;
    {ps_we, stat_clr, err_clr, ps_set, ps_word, ps_wdata} = '0;
    sys_rst = 1'b1;
    repeat (4) @(posedge mclk);
    @(negedge mclk);
    sys_rst = 1'b0;
    chk("latch", 64'h0, ev_latch_ff);
    // Set 3: one element, irq code 5, linked to set 11
    ps(8'h03, 3'h0, 32'h0000_5010);
    ps(8'h03, 3'h1, 32'h0000_0010);
    ps(8'h03, 3'h2, 32'h0001_0001);
    ps(8'h03, 3'h3, 32'h0000_0080);
    ps(8'h03, 3'h5, 32'h0000_000B);
    ps(8'h03, 3'h6, 32'h0000_0001);
    // Set 11: two arrays per event, code 7, rows 8 and 16 bytes apart
    ps(8'h0B, 3'h0, 32'h0000_7011);
    ps(8'h0B, 3'h1, 32'h0000_0010);
    ps(8'h0B, 3'h2, 32'h0002_0001);
    ps(8'h0B, 3'h3, 32'h0000_0088);
    ps(8'h0B, 3'h4, 32'h0010_0008);
    ps(8'h0B, 3'h5, 32'h0000_FFFF);
    ps(8'h0B, 3'h6, 32'h0000_0001);
    ev_in[3] = 1'b1;
    @(negedge mclk);
    ev_in[3] = 1'b0;
    repeat (3) @(negedge mclk);
    chk("latch3", 64'h1, ev_latch_ff[3]);
    chk("ipr_idle", 64'h0, ipr_ff);
    een[3] = 1'b1;
    for (int i = 0; i < 200 && ipr_ff[5] !== 1'b1; i++) @(negedge mclk);
    chk("ipr5", 64'h1, ipr_ff[5]);
    chk("mem16", 64'h2222_2222_2222_2222, u_mdc_mem_model.mem[16]);
    esr_set[3] = 1'b1; // Set 3 now holds the reloaded two-array set
    @(negedge mclk);
    esr_set[3] = 1'b0;
    for (int i = 0; i < 200 && ipr_ff[7] !== 1'b1; i++) @(negedge mclk);
    chk("mem17", 64'h2222_2222_2222_2222, u_mdc_mem_model.mem[17]);
    chk("mem19", 64'h3333_3333_3333_3333, u_mdc_mem_model.mem[19]);
    esr_set[3] = 1'b1; // Reloaded copy is spent, so this must flag
    @(negedge mclk);
    esr_set[3] = 1'b0;
    repeat (4) @(negedge mclk);
    chk("null", 64'h1, null_err_ff);
    ev_in[4] = 1'b1; // Second cycle hits a latched bit
    repeat (2) @(negedge mclk);
    ev_in[4] = 1'b0;
    @(negedge mclk);
    chk("miss4", 64'h1, ev_miss_ff[4]);
    // Quick channel 0 mapped to set 10, trigger word 7
    qen = 8'h01;
    qmap = 64'h0A;
    qtrig = 24'h7;
    ps(8'h0A, 3'h0, 32'h0000_6012);
    ps(8'h0A, 3'h1, 32'h0000_0018);
    ps(8'h0A, 3'h2, 32'h0001_0002);
    ps(8'h0A, 3'h3, 32'h0000_00A0);
    ps(8'h0A, 3'h5, 32'h0000_FFFF);
    ps(8'h0A, 3'h6, 32'h0000_0001);
    ps(8'h0A, 3'h7, 32'h0000_0000);
    for (int i = 0; i < 200 && ipr_ff[6] !== 1'b1; i++) @(negedge mclk);
    chk("ipr6", 64'h1, ipr_ff[6]);
    chk("mem21", 64'h3333_3333_3333_3333, u_mdc_mem_model.mem[21]);
    // Faulting source through queue 1
    ps(8'h0A, 3'h0, 32'h0000_6112);
    ps(8'h0A, 3'h1, 32'hF000_0000);
    ps(8'h0A, 3'h6, 32'h0000_0001);
    ps(8'h0A, 3'h7, 32'h0000_0000);
    for (int i = 0; i < 200 && tc_err_irq_ff !== 1'b1; i++) @(negedge mclk);
    chk("tcerr", 64'h2, tc_err_ff);
    // Let the faulting request drain before reading status
    repeat (20) @(negedge mclk);
    chk("ipr", 64'hE0, ipr_ff);
    chk("qwm", 64'h21, qwm_ff);
    chk("irq_thr", 64'h33, {cc_err_irq_ff, done_irq_ff, qthr_hit_ff});
    // Every clear in one cycle; nothing is pending to set a flag again
    {ipr_clr, miss_clr, err_clr, stat_clr} = '1;
    @(negedge mclk);
    {ipr_clr, miss_clr, err_clr, stat_clr} = '0;
    @(negedge mclk);
    chk("clr", 64'h0, {done_irq_ff, cc_err_irq_ff, ev_miss_ff[4], qwm_ff, qthr_hit_ff,
        tc_err_irq_ff, tc_err_ff, null_err_ff});
    stop_test;
  end
endmodule
